// *** rtl/dac_port_pkg.sv ***
// shared constants for the dac serial write port
package dac_port_pkg;

  // shift register widths of the two device variants
  localparam int WORD_W_WIDE = 24;
  localparam int WORD_W_NARROW = 16;

  // code held by the dac register after reset (power-on to zero)
  localparam logic [23:0] DAC_RESET_CODE = 24'h000000;

  // host timing limits, kept for reference; the bench does not read them
  localparam int SCLK_MAX_MHZ = 30;
  localparam int FRAME_GAP_NS = 33;

  // core clock and the frame gap expressed in core cycles (rounded up)
  localparam int CLK_MHZ = 250;
  localparam int FRAME_GAP_CYC = (FRAME_GAP_NS * CLK_MHZ + 999) / 1000;

  // core cycles to wait for a completion after the busy level drops
  localparam logic [1:0] SETTLE_CYC = 2'h3;

  // abort tracking states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_SETTLE
  } track_e;

endpackage

// *** rtl/word_link_if.sv ***
// carrier between the link-side shifter and the core-side logic
`timescale 1ns/1ps
`default_nettype none

interface word_link_if #(
  parameter int WORD_W = 24
);
  logic [WORD_W-1:0] word;
  logic done_tog;
  logic partial;

  // link side drives, core side samples
  modport link (output word, output done_tog, output partial);
  modport core (input word, input done_tog, input partial);
endinterface

`default_nettype wire

// *** rtl/serial_shifter.sv ***
// shifter clocked by the serial clock falling edge
`timescale 1ns/1ps
`default_nettype none

module serial_shifter #(
  parameter int WORD_W = 24
) (
  // link pins
  input wire logic sclk,
  input wire logic frame_sel_n,
  input wire logic sdin,
  // reset
  input wire logic rstn,
  // to the core
  word_link_if.link lnk
);

  localparam int CW = $clog2(WORD_W + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(WORD_W);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  logic frame_rst_n;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [WORD_W-1:0] shreg_q, shreg_d;
  logic partial_q, partial_d;
  logic [WORD_W-1:0] word_q, word_d;
  logic tog_q, tog_d;

  // frame high clears the frame state; abort drops the partial word
  assign frame_rst_n = rstn & ~frame_sel_n;

  // next values of the frame and result groups
  always_comb begin
    cnt_d = cnt_q;
    shreg_d = shreg_q;
    word_d = word_q;
    tog_d = tog_q;
    if (cnt_q != CNT_FULL) begin
      shreg_d = {shreg_q[WORD_W-2:0], sdin};
      cnt_d = cnt_q + CNT_ONE;
      if (cnt_q == CNT_FULL - CNT_ONE) begin
        word_d = {shreg_q[WORD_W-2:0], sdin};
        tog_d = ~tog_q;
      end
    end
    partial_d = (cnt_d != CNT_FULL) && (cnt_d != '0);
  end

  // frame state, cleared while frame select is high
  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt_q <= '0;
      shreg_q <= '0;
      partial_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      shreg_q <= shreg_d;
      partial_q <= partial_d;
    end
  end

  // completed word and its event toggle survive frame select
  always_ff @(negedge sclk or negedge rstn) begin
    if (!rstn) begin
      word_q <= '0;
      tog_q <= 1'b0;
    end else begin
      word_q <= word_d;
      tog_q <= tog_d;
    end
  end

  assign lnk.word = word_q;
  assign lnk.done_tog = tog_q;
  assign lnk.partial = partial_q;

endmodule

`default_nettype wire

// *** rtl/dac_serial_write_port.sv ***
// top of the dac serial write port: link shifter and core-side commit
//
// Notes on behaviour
// - frame select is active low; bits are accepted only while it is low.
// - one data bit is sampled on each of the first WORD_W serial clock falling edges in a frame.
// - shift register is 24 bits wide, or 16 for the narrower variants.
// - the dac is updated only after the final counted falling edge.
// - frame select rising early aborts; the dac stays unchanged.
// - the received word is committed to the dac register on the third core clock edge after the last bit.
`timescale 1ns/1ps
`default_nettype none

module dac_serial_write_port #(
  parameter int WORD_W = dac_port_pkg::WORD_W_WIDE
) (
  // core clock and reset
  input wire logic clk,
  input wire logic rstn,
  // serial link from the host
  input wire logic sclk,
  input wire logic frame_sel_n,
  input wire logic sdin,
  // committed word towards the converter
  output logic [WORD_W-1:0] dac_code,
  output logic dac_load,
  // frame status
  output logic frame_active,
  output logic frame_abort
);

  // word width is one of the two documented sizes
  initial begin
    if (WORD_W != dac_port_pkg::WORD_W_WIDE && WORD_W != dac_port_pkg::WORD_W_NARROW) begin
      $error("unsupported word width");
    end
  end

  // carrier between the two clock domains
  word_link_if #(.WORD_W(WORD_W)) lnk ();

  // link-side shifter, falling edge of the serial clock
  serial_shifter #(
    .WORD_W(WORD_W)
  ) u_shifter (
    .sclk(sclk),
    .frame_sel_n(frame_sel_n),
    .sdin(sdin),
    .rstn(rstn),
    .lnk(lnk)
  );

  // core reset: asserted at once, released two clock edges late,
  // so no core flop sees the raw release land near an edge; the
  // shifter keeps the raw reset since its clock is still then
  logic rst_s1_q, rst_s1_d;
  logic rst_s2_q, rst_s2_d;
  logic core_rstn;

  // reset synchroniser next values
  always_comb begin
    rst_s1_d = 1'b1;
    rst_s2_d = rst_s1_q;
  end

  // reset synchroniser flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= rst_s1_d;
      rst_s2_q <= rst_s2_d;
    end
  end

  // synchronised core reset, active low
  assign core_rstn = rst_s2_q;

  // synchroniser flops: select pin, partial flag and done toggle,
  // each read only after its second stage
  logic frame_s1_q, frame_s1_d;
  logic frame_s2_q, frame_s2_d;
  logic part_s1_q, part_s1_d;
  logic part_s2_q, part_s2_d;
  logic tog_s1_q, tog_s1_d;
  logic tog_s2_q, tog_s2_d;
  logic tog_s3_q, tog_s3_d;

  // completion event in the core domain
  logic done_evt;

  // synchroniser next values; the third toggle stage only
  // remembers the last value for the change detect
  always_comb begin
    frame_s1_d = frame_sel_n;
    frame_s2_d = frame_s1_q;
    part_s1_d = lnk.partial;
    part_s2_d = part_s1_q;
    tog_s1_d = lnk.done_tog;
    tog_s2_d = tog_s1_q;
    tog_s3_d = tog_s2_q;
  end

  // synchroniser registers
  always_ff @(posedge clk or negedge core_rstn) begin
    if (!core_rstn) begin
      frame_s1_q <= 1'b1;
      frame_s2_q <= 1'b1;
      part_s1_q <= 1'b0;
      part_s2_q <= 1'b0;
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end else begin
      frame_s1_q <= frame_s1_d;
      frame_s2_q <= frame_s2_d;
      part_s1_q <= part_s1_d;
      part_s2_q <= part_s2_d;
      tog_s1_q <= tog_s1_d;
      tog_s2_q <= tog_s2_d;
      tog_s3_q <= tog_s3_d;
    end
  end

  // toggle change marks one completed frame
  assign done_evt = tog_s2_q ^ tog_s3_q;

  // dac register and load strobe; the code keeps its value
  // through aborted frames
  logic [WORD_W-1:0] code_q, code_d;
  logic load_q, load_d;

  // the shifter holds its word steady until the next full frame,
  // far longer than the synchroniser latency, so sampling is safe
  always_comb begin
    code_d = code_q;
    load_d = 1'b0;
    if (done_evt) begin
      code_d = lnk.word;
      load_d = 1'b1;
    end
  end

  // commit registers
  always_ff @(posedge clk or negedge core_rstn) begin
    if (!core_rstn) begin
      code_q <= dac_port_pkg::DAC_RESET_CODE[WORD_W-1:0];
      load_q <= 1'b0;
    end else begin
      code_q <= code_d;
      load_q <= load_d;
    end
  end

  // abort tracking: busy and completion cross by separate
  // synchronisers, so they may arrive a cycle apart; a short
  // grace window separates a clean finish from an early stop
  dac_port_pkg::track_e st_q, st_d;
  logic [1:0] grace_q, grace_d;
  logic abort_q, abort_d;
  logic active_q, active_d;

  // tracker next values
  always_comb begin
    st_d = st_q;
    grace_d = grace_q;
    abort_d = 1'b0;
    active_d = ~frame_s2_q;
    case (st_q)
      dac_port_pkg::ST_IDLE: begin
        if (part_s2_q) begin
          st_d = dac_port_pkg::ST_SHIFT;
        end
      end
      dac_port_pkg::ST_SHIFT: begin
        if (done_evt) begin
          st_d = dac_port_pkg::ST_IDLE;
        end else if (!part_s2_q) begin
          st_d = dac_port_pkg::ST_SETTLE;
          grace_d = dac_port_pkg::SETTLE_CYC;
        end
      end
      dac_port_pkg::ST_SETTLE: begin
        if (done_evt) begin
          st_d = dac_port_pkg::ST_IDLE;
        end else if (grace_q == 2'h0) begin
          st_d = dac_port_pkg::ST_IDLE;
          abort_d = 1'b1;
        end else begin
          grace_d = grace_q - 2'h1;
        end
      end
      default: begin
        st_d = dac_port_pkg::ST_IDLE;
      end
    endcase
  end

  // tracker registers; abort is a one-cycle pulse, never
  // raised in the cycle of a load
  always_ff @(posedge clk or negedge core_rstn) begin
    if (!core_rstn) begin
      st_q <= dac_port_pkg::ST_IDLE;
      grace_q <= 2'h0;
      abort_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      st_q <= st_d;
      grace_q <= grace_d;
      abort_q <= abort_d;
      active_q <= active_d;
    end
  end

  // outputs straight from flops; dac_code is steady from the
  // cycle dac_load is high until the next completed frame
  assign dac_code = code_q;
  assign dac_load = load_q;
  assign frame_active = active_q;
  assign frame_abort = abort_q;

endmodule

`default_nettype wire

// *** test/dac_port_assertions.sv ***
// port assertions for the dac serial write port
`timescale 1ns/1ps
`default_nettype none
module dac_port_assertions #(
  parameter int WORD_W = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // watched ports
  input wire logic frame_sel_n,
  input wire logic [WORD_W-1:0] dac_code,
  input wire logic dac_load,
  input wire logic frame_active,
  input wire logic frame_abort
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // code moves only with a load pulse
  property p_code_moves; $changed(dac_code) |-> dac_load; endproperty
  a_code_moves: assert property (p_code_moves) else $error("code moved without load");
  // load is a single pulse
  property p_load_one; dac_load |=> !dac_load; endproperty
  a_load_one: assert property (p_load_one) else $error("load too long");
  // abort is a single pulse
  property p_abort_one; frame_abort |=> !frame_abort; endproperty
  a_abort_one: assert property (p_abort_one) else $error("abort too long");
  // abort leaves the code alone
  property p_abort_keep; frame_abort |-> $stable(dac_code) && !dac_load; endproperty
  a_abort_keep: assert property (p_abort_keep) else $error("abort changed code");
  // frame status follows select
  property p_idle; frame_sel_n [*6] |-> !frame_active; endproperty
  a_idle: assert property (p_idle) else $error("active while deselected");
  property p_busy; !frame_sel_n [*6] |-> frame_active; endproperty
  a_busy: assert property (p_busy) else $error("inactive while selected");
  // no commit long after the frame closed
  property p_no_late; frame_sel_n [*8] |-> !dac_load; endproperty
  a_no_late: assert property (p_no_late) else $error("load while idle");
endmodule
bind dac_serial_write_port dac_port_assertions #(.WORD_W(WORD_W)) dac_port_assertions_inst (.clk(clk),
  .rstn(rstn), .frame_sel_n(frame_sel_n), .dac_code(dac_code), .dac_load(dac_load),
  .frame_active(frame_active), .frame_abort(frame_abort));
`default_nettype wire

// *** test/dac_host_model.sv ***
// serial master model driving the write port
`timescale 1ns/1ps
`default_nettype none
module dac_host_model #(
  parameter int WORD_W = 24
) (
  // link pins
  output var logic sclk,
  output var logic frame_sel_n,
  output var logic sdin
);
  // idle: clock still, select high
  initial begin
    sclk = 1'b1;
    frame_sel_n = 1'b1;
    sdin = 1'b0;
  end
  // one frame of nbits falling edges, 36 ns period
  task automatic send(input logic [WORD_W-1:0] w, input int nbits);
    #1.5; // keep link edges off the core clock edges
    frame_sel_n = 1'b0;
    #18;
    for (int i = 0; i < nbits; i++) begin
      sdin = (i < WORD_W) ? w[WORD_W-1-i] : ~sdin;
      #9 sclk = 1'b0;
      #18 sclk = 1'b1;
      #9;
    end
    frame_sel_n = 1'b1;
    sdin = ~sdin;
    #36;
  endtask
endmodule
`default_nettype wire

// *** test/tb_dac_serial_write_port.sv ***
// testbench for the dac serial write port
`timescale 1ns/1ps
`default_nettype none
module tb_dac_serial_write_port;
  logic clk, rstn, sclk, frame_sel_n, sdin, dac_load, frame_active, frame_abort;
  logic [23:0] dac_code, got;
  int miscompares = 0, check_count = 0, loads = 0, aborts = 0;
  // 250 MHz core clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  dac_host_model host_inst (.sclk(sclk), .frame_sel_n(frame_sel_n), .sdin(sdin));
  dac_serial_write_port dac_serial_write_port_inst (.clk(clk), .rstn(rstn), .sclk(sclk),
    .frame_sel_n(frame_sel_n), .sdin(sdin), .dac_code(dac_code), .dac_load(dac_load),
    .frame_active(frame_active), .frame_abort(frame_abort));
  // count load and abort pulses
  always @(posedge clk) begin
    if (dac_load === 1'b1) begin
      loads++;
      got = dac_code;
    end
    if (frame_abort === 1'b1) aborts++;
  end
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] seen);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // bounded wait for a pulse count
  task automatic wait_count(ref int cnt, input int want);
    int n;
    n = 0;
    while (cnt < want && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (cnt < want) begin
      miscompares++;
      $display("BAD wait expected %0d seen %0d", want, cnt);
      tally_and_finish();
    end
  endtask
  // full frame commits msb first
  task automatic t_full(input logic [23:0] w);
    int l, a;
    l = loads;
    a = aborts;
    host_inst.send(w, 24);
    wait_count(loads, l + 1);
    chk("load word", w, got);
    chk("dac_code", w, dac_code);
    chk("clean aborts", 24'(a), 24'(aborts));
  endtask
  // short frame is dropped
  task automatic t_abort();
    int a, l;
    a = aborts;
    l = loads;
    host_inst.send(24'hFFFFFF, 10);
    wait_count(aborts, a + 1);
    chk("loads", 24'(l), 24'(loads));
    chk("kept code", 24'h5A3CF0, dac_code);
  endtask
  // edges past the word are ignored
  task automatic t_over();
    int l, a;
    l = loads;
    a = aborts;
    host_inst.send(24'hC3A50F, 27);
    wait_count(loads, l + 1);
    chk("over code", 24'hC3A50F, dac_code);
    chk("over loads", 24'(l + 1), 24'(loads));
    chk("active", 24'h000000, {23'h0, frame_active});
    chk("over aborts", 24'(a), 24'(aborts));
  endtask
  // reset then scenarios
  initial begin
    rstn = 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    chk("reset code", 24'h000000, dac_code);
    repeat (2) @(posedge clk);
    t_full(24'hA5C30F);
    t_full(24'h5A3CF0);
    t_abort();
    t_over();
    tally_and_finish();
  end
endmodule
`default_nettype wire
